// ==== rtl/pmic_pkg.sv ====
// Package for the power management register bank: offsets, field positions,
// reset values and the structs that carry configuration and status.
// Assumes one clock domain and an 8-bit register port from the serial engine.
`default_nettype none

package pmic_pkg;

    // ========================================================================
    // Sizes
    // ========================================================================
    localparam int unsigned NCH = 8;       // Regulator channels.
    localparam int unsigned NSS = 4;       // Channels 5..8 own a soft start select.
    localparam int unsigned SS_BASE = 4;   // Channel index of the first of them.
    localparam int unsigned CH7 = 6;       // Zero-based index of channel 7.
    localparam int unsigned CH8 = 7;       // Zero-based index of channel 8.

    // ========================================================================
    // Register offsets
    // ========================================================================
    localparam logic [7:0] OFS_SEQ = 8'h01;
    localparam logic [7:0] OFS_GRP = 8'h02;
    localparam logic [7:0] OFS_START = 8'h03;
    localparam logic [7:0] OFS_FAULT = 8'h18;
    localparam logic [7:0] OFS_BUS = 8'h19;
    localparam logic [7:0] OFS_TRIM3 = 8'h49;
    localparam logic [7:0] OFS_CH7EN = 8'h58;
    localparam logic [7:0] OFS_CH7LVL = 8'h59;
    localparam logic [7:0] OFS_SET [NCH] = '{8'h04, 8'h06, 8'h08, 8'h0A,
                                              8'h0C, 8'h0F, 8'h12, 8'h15};
    localparam logic [7:0] OFS_STAT [NCH] = '{8'h05, 8'h07, 8'h09, 8'h0B,
                                               8'h0E, 8'h11, 8'h14, 8'h17};
    localparam logic [7:0] OFS_SS [NSS] = '{8'h0D, 8'h10, 8'h13, 8'h16};

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int B_SEQ_LO = 0;
    localparam int B_SEQ_HI = 1;
    localparam int B_DLY_LO = 2;
    localparam int B_DLY_HI = 3;
    localparam int B_GRP_LO = 0;
    localparam int B_GRP_HI = 3;
    localparam int B_SOFTOFF = 4;
    localparam int B_SSL_LO = 0;
    localparam int B_SSL_HI = 1;
    localparam int B_COLD = 3;
    localparam int B_HOFF = 4;
    localparam int B_RESP = 0;
    localparam int B_TGT_LO = 1;
    localparam int B_TGT_HI = 4;
    localparam int B_DONE = 0;
    localparam int B_FLT_LO = 1;
    localparam int B_FLT_HI = 5;
    localparam int B_SS_LO = 0;
    localparam int B_SS_HI = 1;
    localparam int B_FREQ_LO = 2;
    localparam int B_FREQ_HI = 3;
    localparam int B_MODE_LO = 2;
    localparam int B_MODE_HI = 3;
    localparam int B_LED_LO = 4;
    localparam int B_LED_HI = 6;
    localparam int B_ACC = 0;
    localparam int B_DIS = 4;
    localparam int B_EN_LO = 6;
    localparam int B_EN_HI = 7;

    // Channel 7 has only undervoltage and overvoltage detectors.
    localparam logic [4:0] FLT_MASK_CH7 = 5'h03;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Cycles after reset release before the pin value is trusted (sync depth).
    localparam logic [1:0] CAP_WAIT = 2'h2;

    // ========================================================================
    // Types
    // ========================================================================
    // Fault vector per channel: {thermal, short, current limit, under, over}.
    typedef struct packed {
        logic [1:0] pin_softstart_latch;
        logic [NCH-1:0] scaling_done_flag;
        logic [NCH-1:0][4:0] fault;
    } pmic_stat_t;

    typedef struct packed {
        logic [1:0] group_sequence_select;
        logic [1:0] hard_off_delay_select;
        logic [3:0] group_power_bits;
        logic global_soft_off;
        logic [1:0] pin_softstart_latch;
        logic cold_boot_flag;
        logic hard_off_flag;
        logic [NCH-1:0] voltage_fault_response;
        logic [NCH-1:0][3:0] scaling_target;
        logic [NSS-1:0][1:0] channel_softstart_select;
        logic [1:0] upper_channel_frequency;
        logic [1:0] ch8_regulation_select;
        logic [2:0] led_current_step;
        logic accurate_mode;
        logic [7:0] ch3_trim_bits;
        logic ch7_discharge_bit;
        logic ch7_first_enable;
        logic ch7_second_enable;
        logic [7:0] ch7_level_bits;
    } pmic_cfg_t;

    typedef struct packed {
        pmic_cfg_t cfg;
        pmic_stat_t s1;
        pmic_stat_t s2;
        logic [1:0] cap_cnt;
        logic captured;
        logic [7:0] rdata;
        logic rvalid;
    } pmic_core_t;

    typedef struct packed {
        logic pend;
        logic [7:0] paddr;
        logic [7:0] pdata;
        logic commit;
        logic [7:0] caddr;
        logic [7:0] cdata;
    } pmic_filt_t;

    localparam pmic_cfg_t CFG_RST = '0;
    localparam pmic_stat_t STAT_RST = '0;
    localparam pmic_filt_t FILT_RST = '0;

endpackage : pmic_pkg

`default_nettype wire

// ==== rtl/pmic_wr_filter.sv ====
// Write filter between the serial engine and the register bank.
// Assumes writes arrive as one-cycle strobes on the bank clock.
`default_nettype none

module pmic_wr_filter
    import pmic_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Mode and incoming write.
    input wire logic accurate_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] data_in,
    // Accepted write.
    output logic commit_out,
    output logic [7:0] addr_out,
    output logic [7:0] data_out
);

    // ========================================================================
    // Duplicate check
    // ========================================================================
    pmic_filt_t st_r;
    pmic_filt_t st_nxt;

    // In accurate mode a write takes effect only when its twin matches; a
    // mismatching copy becomes the new first copy, so one corrupted byte
    // costs one command rather than wedging the filter.
    always_comb begin
        st_nxt = st_r;
        st_nxt.commit = 1'b0;
        if (wr_in) begin
            if (!accurate_in) begin
                st_nxt.commit = 1'b1;
                st_nxt.caddr = addr_in;
                st_nxt.cdata = data_in;
                st_nxt.pend = 1'b0;
            end else if (st_r.pend && st_r.paddr == addr_in && st_r.pdata == data_in) begin
                st_nxt.commit = 1'b1;
                st_nxt.caddr = addr_in;
                st_nxt.cdata = data_in;
                st_nxt.pend = 1'b0;
            end else begin
                st_nxt.pend = 1'b1;
                st_nxt.paddr = addr_in;
                st_nxt.pdata = data_in;
            end
        end
    end

    // State register.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            st_r <= FILT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign commit_out = st_r.commit;
    assign addr_out = st_r.caddr;
    assign data_out = st_r.cdata;

    // ========================================================================
    // Checks
    // ========================================================================
    sequence s_first_copy;
        accurate_in && wr_in && !st_r.pend;
    endsequence

    property p_single_copy_held;
        @(posedge ref_clk_in) disable iff (reset_in)
        s_first_copy |=> !commit_out;
    endproperty
    a_single_copy_held: assert property (p_single_copy_held)
        else $error("Accurate mode committed a single copy.");

    property p_twin_commits;
        @(posedge ref_clk_in) disable iff (reset_in)
        (s_first_copy ##1 (accurate_in && wr_in && addr_in == $past(addr_in)
            && data_in == $past(data_in))) |=> (commit_out && data_out == $past(data_in));
    endproperty
    a_twin_commits: assert property (p_twin_commits)
        else $error("Matching twin write was not committed.");

endmodule // pmic_wr_filter

`default_nettype wire

// ==== rtl/pmic_regbank.sv ====
// Register bank of the multi-channel regulator controller.
// Assumes the serial engine hands over byte writes and reads as one-cycle
// strobes on ref_clk_in; detector status and the soft start pin are async.
`default_nettype none

module pmic_regbank
    import pmic_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Register port from the serial engine.
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Detector status, soft start pin and startup events.
    input wire pmic_stat_t stat_in,
    input wire logic cold_boot_evt_in,
    input wire logic hard_off_evt_in,
    // Configuration towards the regulators.
    output pmic_cfg_t cfg_out
);

    // ========================================================================
    // Write filter
    // ========================================================================
    logic wr_commit;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    pmic_core_t st_r;
    pmic_core_t st_nxt;

    pmic_wr_filter u_filter (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .accurate_in(st_r.cfg.accurate_mode),
        .wr_in(reg_wr_in),
        .addr_in(reg_addr_in),
        .data_in(reg_wdata_in),
        .commit_out(wr_commit),
        .addr_out(wr_addr),
        .data_out(wr_data)
    );

    // ========================================================================
    // Fault summary
    // ========================================================================
    logic [NCH-1:0] fault_any;
    logic [NCH-1:0][4:0] fault_vis;

    // Channel 7 has no thermal, short or limit detector, so those inputs are
    // masked here rather than trusting the analog side to tie them low.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            fault_vis[i] = stat_in_sync(i);
            fault_any[i] = |fault_vis[i];
        end
    end

    function automatic logic [4:0] stat_in_sync(input int ch);
        logic [4:0] v;
        v = st_r.s2.fault[ch];
        if (ch == CH7) begin
            v = v & FLT_MASK_CH7;
        end
        return v;
    endfunction

    // ========================================================================
    // Read multiplexer
    // ========================================================================
    logic [7:0] rd_byte;

    // Every bit not assigned below stays zero, so reserved bits and unmapped
    // addresses read as zero without a separate decode.
    always_comb begin
        rd_byte = BYTE_ZERO;
        case (reg_addr_in)
            OFS_SEQ: begin
                rd_byte[B_SEQ_HI:B_SEQ_LO] = st_r.cfg.group_sequence_select;
                rd_byte[B_DLY_HI:B_DLY_LO] = st_r.cfg.hard_off_delay_select;
            end
            OFS_GRP: begin
                rd_byte[B_GRP_HI:B_GRP_LO] = st_r.cfg.group_power_bits;
                rd_byte[B_SOFTOFF] = st_r.cfg.global_soft_off;
            end
            OFS_START: begin
                rd_byte[B_SSL_HI:B_SSL_LO] = st_r.cfg.pin_softstart_latch;
                rd_byte[B_COLD] = st_r.cfg.cold_boot_flag;
                rd_byte[B_HOFF] = st_r.cfg.hard_off_flag;
            end
            OFS_FAULT: begin
                rd_byte = fault_any;
            end
            OFS_BUS: begin
                rd_byte[B_ACC] = st_r.cfg.accurate_mode;
            end
            OFS_TRIM3: begin
                rd_byte = st_r.cfg.ch3_trim_bits;
            end
            OFS_CH7EN: begin
                rd_byte[B_DIS] = st_r.cfg.ch7_discharge_bit;
                rd_byte[B_EN_LO] = st_r.cfg.ch7_first_enable;
                rd_byte[B_EN_HI] = st_r.cfg.ch7_second_enable;
            end
            OFS_CH7LVL: begin
                rd_byte = st_r.cfg.ch7_level_bits;
            end
            default: begin
            end
        endcase
        for (int i = 0; i < NCH; i++) begin
            if (reg_addr_in == OFS_SET[i]) begin
                rd_byte[B_RESP] = st_r.cfg.voltage_fault_response[i];
                rd_byte[B_TGT_HI:B_TGT_LO] = st_r.cfg.scaling_target[i];
            end
            if (reg_addr_in == OFS_STAT[i]) begin
                rd_byte[B_DONE] = st_r.s2.scaling_done_flag[i];
                rd_byte[B_FLT_HI:B_FLT_LO] = fault_vis[i];
            end
        end
        for (int j = 0; j < NSS; j++) begin
            if (reg_addr_in == OFS_SS[j]) begin
                rd_byte[B_SS_HI:B_SS_LO] = st_r.cfg.channel_softstart_select[j];
                if (j + SS_BASE == CH7) begin
                    rd_byte[B_FREQ_HI:B_FREQ_LO] = st_r.cfg.upper_channel_frequency;
                end
                if (j + SS_BASE == CH8) begin
                    rd_byte[B_MODE_HI:B_MODE_LO] = st_r.cfg.ch8_regulation_select;
                    rd_byte[B_LED_HI:B_LED_LO] = st_r.cfg.led_current_step;
                end
            end
        end
    end

    // ========================================================================
    // Next state
    // ========================================================================
    // Writes only touch the fields named for each address; read-only status
    // never enters the write path. Hardware events are ORed in after the
    // write so that an event landing on a clearing write is kept.
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = stat_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.rvalid = reg_rd_in;
        if (reg_rd_in) begin
            st_nxt.rdata = rd_byte;
        end
        if (wr_commit) begin
            case (wr_addr)
                OFS_SEQ: begin
                    st_nxt.cfg.group_sequence_select = wr_data[B_SEQ_HI:B_SEQ_LO];
                    st_nxt.cfg.hard_off_delay_select = wr_data[B_DLY_HI:B_DLY_LO];
                end
                OFS_GRP: begin
                    st_nxt.cfg.group_power_bits = wr_data[B_GRP_HI:B_GRP_LO];
                    st_nxt.cfg.global_soft_off = wr_data[B_SOFTOFF];
                end
                OFS_START: begin
                    st_nxt.cfg.cold_boot_flag = wr_data[B_COLD];
                    st_nxt.cfg.hard_off_flag = wr_data[B_HOFF];
                end
                OFS_BUS: begin
                    st_nxt.cfg.accurate_mode = wr_data[B_ACC];
                end
                OFS_TRIM3: begin
                    st_nxt.cfg.ch3_trim_bits = wr_data;
                end
                OFS_CH7EN: begin
                    st_nxt.cfg.ch7_discharge_bit = wr_data[B_DIS];
                    st_nxt.cfg.ch7_first_enable = wr_data[B_EN_LO];
                    st_nxt.cfg.ch7_second_enable = wr_data[B_EN_HI];
                end
                OFS_CH7LVL: begin
                    st_nxt.cfg.ch7_level_bits = wr_data;
                end
                default: begin
                end
            endcase
            for (int i = 0; i < NCH; i++) begin
                if (wr_addr == OFS_SET[i]) begin
                    st_nxt.cfg.voltage_fault_response[i] = wr_data[B_RESP];
                    st_nxt.cfg.scaling_target[i] = wr_data[B_TGT_HI:B_TGT_LO];
                end
            end
            for (int j = 0; j < NSS; j++) begin
                if (wr_addr == OFS_SS[j]) begin
                    st_nxt.cfg.channel_softstart_select[j] = wr_data[B_SS_HI:B_SS_LO];
                    if (j + SS_BASE == CH7) begin
                        st_nxt.cfg.upper_channel_frequency =
                            wr_data[B_FREQ_HI:B_FREQ_LO];
                    end
                    if (j + SS_BASE == CH8) begin
                        st_nxt.cfg.ch8_regulation_select =
                            wr_data[B_MODE_HI:B_MODE_LO];
                        st_nxt.cfg.led_current_step = wr_data[B_LED_HI:B_LED_LO];
                    end
                end
            end
        end
        if (cold_boot_evt_in) begin
            st_nxt.cfg.cold_boot_flag = 1'b1;
        end
        if (hard_off_evt_in) begin
            st_nxt.cfg.hard_off_flag = 1'b1;
        end
        // The pin is caught once, after the synchroniser has filled, and
        // also seeds the per-channel soft start selects of channels 5..8.
        if (!st_r.captured) begin
            if (st_r.cap_cnt == CAP_WAIT) begin
                st_nxt.captured = 1'b1;
                st_nxt.cfg.pin_softstart_latch = st_r.s2.pin_softstart_latch;
                for (int j = 0; j < NSS; j++) begin
                    st_nxt.cfg.channel_softstart_select[j] = st_r.s2.pin_softstart_latch;
                end
            end else begin
                st_nxt.cap_cnt = st_r.cap_cnt + 2'h1;
            end
        end
    end

    // State register; reset loads constants only.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            st_r <= '{cfg: CFG_RST, s1: STAT_RST, s2: STAT_RST, cap_cnt: 2'h0,
                      captured: 1'b0, rdata: BYTE_ZERO, rvalid: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out = st_r.rdata;
    assign reg_rvalid_out = st_r.rvalid;
    assign cfg_out = st_r.cfg;

    // ========================================================================
    // Checks
    // ========================================================================
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_wr(logic [7:0] a);
        wr_commit && wr_addr == a;
    endsequence

    property p_soft_off;
        s_wr(OFS_GRP) |=> cfg_out.global_soft_off == $past(wr_data[B_SOFTOFF]);
    endproperty
    a_soft_off: assert property (p_soft_off)
        else $error("Soft shutdown bit did not follow the write.");

    property p_latch_ro;
        (st_r.captured and s_wr(OFS_START)) |=> $stable(cfg_out.pin_softstart_latch);
    endproperty
    a_latch_ro: assert property (p_latch_ro)
        else $error("Latched soft start value changed on a write.");

    property p_cold_set_wins;
        cold_boot_evt_in |=> cfg_out.cold_boot_flag;
    endproperty
    a_cold_set_wins: assert property (p_cold_set_wins)
        else $error("Cold start event was lost.");

    property p_hoff_set_wins;
        hard_off_evt_in |=> cfg_out.hard_off_flag;
    endproperty
    a_hoff_set_wins: assert property (p_hoff_set_wins)
        else $error("Hard shutdown event was lost.");

    property p_done_read;
        (reg_rd_in && reg_addr_in == OFS_STAT[0])
            |=> reg_rvalid_out && reg_rdata_out[B_DONE] == $past(st_r.s2.scaling_done_flag[0]);
    endproperty
    a_done_read: assert property (p_done_read)
        else $error("Scaling done flag misread.");

    property p_ch7_status;
        (reg_rd_in && reg_addr_in == OFS_STAT[CH7]) |=> reg_rdata_out[7:3] == 5'h00;
    endproperty
    a_ch7_status: assert property (p_ch7_status)
        else $error("Channel 7 status shows unsupported fault bits.");

    property p_summary;
        (reg_rd_in && reg_addr_in == OFS_FAULT) |=> reg_rdata_out == $past(fault_any);
    endproperty
    a_summary: assert property (p_summary)
        else $error("Fault summary does not match channel fault_summary.");

    property p_trim_write;
        s_wr(OFS_TRIM3) |=> cfg_out.ch3_trim_bits == $past(wr_data);
    endproperty
    a_trim_write: assert property (p_trim_write)
        else $error("Channel 3 trim did not take the written value.");

    property p_unmapped;
        (reg_rd_in && reg_addr_in == BYTE_ZERO) |=> reg_rdata_out == BYTE_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped address read nonzero.");

endmodule // pmic_regbank

`default_nettype wire

// ==== tb/pmic_host_model.sv ====
// Host side model: issues byte reads and writes on the bank's register port.
// Assumes its tasks are entered just after a rising clock edge.
`default_nettype none

module pmic_host_model (
    // Clock and answer.
    input wire logic ref_clk_in,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    // Request.
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========
    // Access tasks
    // ========
    // Idle port starts quiet.
    initial {wr_out, rd_out, addr_out, wdata_out} = '0;

    // Accurate mode wants every byte twice, so copies is 2 there.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int copies);
        wr_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        repeat (copies) @(posedge ref_clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
        repeat (3) @(posedge ref_clk_in);
    endtask

    // Data is valid just after the taking edge, which registers it.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        rd_out <= 1'b1;
        addr_out <= a;
        @(posedge ref_clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        ok = rvalid_in;
        d = rdata_in;
        @(posedge ref_clk_in);
    endtask
endmodule // pmic_host_model

`default_nettype wire

// ==== tb/pmic_register_map_test.sv ====
// Self-checking bench for the register bank: readback table and accurate mode.
// Assumes bank and host model share one 250 MHz clock.
`default_nettype none

module pmic_register_map_test import pmic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic wr, rd, rvalid, ok;
    logic [7:0] addr, wdata, rdata, got;
    pmic_stat_t stat = STAT_RST;
    logic cold_evt = 1'b0;
    logic hoff_evt = 1'b0;
    int n_fail = 0;
    int checked = 0;
    pmic_cfg_t cfg;
    // The host's 1 ms settle before the second enable is cut to 1 us: the bank
    // does not time it, and the full wait would blow the run's cycle budget.
    localparam int CH7_GAP = 250;
    localparam logic [7:0] ADR [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0D, 8'h13, 8'h16,
        8'h49, 8'h58, 8'h59, 8'h05, 8'h14, 8'h18, 8'h00};
    localparam logic [7:0] EXP [14] = '{8'h0F, 8'h1F, 8'h1A, 8'h1F, 8'h03, 8'h0F, 8'h7F,
        8'hFF, 8'hD0, 8'hFF, 8'h2B, 8'h06, 8'h41, 8'h00};

    // ========
    // Clock and parts
    // ========
    // Half period of 2 ns gives 250 MHz.
    always #2 ref_clk_in = ~ref_clk_in;

    pmic_regbank i_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .stat_in(stat), .cold_boot_evt_in(cold_evt),
        .hard_off_evt_in(hoff_evt), .cfg_out(cfg));
    pmic_host_model i_host (.ref_clk_in(ref_clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
        .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));

    // ========
    // Checking
    // ========
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, got, ok);
        check({7'h00, ok}, 8'h01);
        check(got, exp);
    endtask

    // All ones is written at every table address; writable bits read back set, read-only bits show the fixed status and latched pin.
    task automatic run(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            i_host.wr(ADR[i], 8'hFF, 1);
            rd_chk(ADR[i], EXP[i]);
        end
    endtask

    task automatic print_verdict;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hang counts as a failure.
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end

    // Status is fixed before reset so the pin capture sees it.
    initial begin
        stat.pin_softstart_latch <= 2'h2;
        stat.scaling_done_flag <= 8'h01;
        stat.fault[0] <= 5'h15;
        stat.fault[CH7] <= 5'h1F;
        repeat (8) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        run(0, 3);
        run(4, 6);
        run(7, 9);
        run(10, 13);
        // Clearing the flags must leave the latched pin value alone.
        i_host.wr(OFS_START, 8'h00, 1);
        rd_chk(OFS_START, 8'h02);
        // Events land on the very edge that commits a clearing write; set wins.
        fork
            i_host.wr(OFS_START, 8'h00, 1);
            begin
                @(posedge ref_clk_in);
                cold_evt <= 1'b1;
                hoff_evt <= 1'b1;
                @(posedge ref_clk_in);
                cold_evt <= 1'b0;
                hoff_evt <= 1'b0;
            end
        join
        rd_chk(OFS_START, 8'h1A);
        check({7'h00, cfg.global_soft_off}, 8'h01);
        i_host.wr(OFS_BUS, 8'h01, 1);
        rd_chk(OFS_BUS, 8'h01);
        i_host.wr(OFS_CH7LVL, 8'h33, 1);
        rd_chk(OFS_CH7LVL, 8'hFF);
        i_host.wr(OFS_CH7LVL, 8'h44, 2);
        rd_chk(OFS_CH7LVL, 8'h44);
        // A fresh twin with nothing pending turns accurate mode back off.
        i_host.wr(OFS_BUS, 8'h00, 2);
        rd_chk(OFS_BUS, 8'h00);
        // Independent channel 7 start: first enable with discharge clear, wait,
        // second enable, then ramp the level up from zero.
        i_host.wr(OFS_CH7EN, 8'h40, 1);
        rd_chk(OFS_CH7EN, 8'h40);
        repeat (CH7_GAP) @(posedge ref_clk_in);
        i_host.wr(OFS_CH7EN, 8'hC0, 1);
        i_host.wr(OFS_CH7LVL, 8'h00, 1);
        rd_chk(OFS_CH7LVL, 8'h00);
        i_host.wr(OFS_CH7LVL, 8'h04, 1);
        rd_chk(OFS_CH7LVL, 8'h04);
        check({6'h00, cfg.ch7_second_enable, cfg.ch7_first_enable}, 8'h03);
        print_verdict();
    end
endmodule // pmic_register_map_test

`default_nettype wire
